// file: rtl/event_tally.sv
`timescale 1ns/1ns
`default_nettype none
module event_tally
	import perf_monitor_pkg::*;
#(
	parameter int W = CNT_W
) (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic         inc,
	input  wire logic         clear,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	input  wire logic         flag_clr,
	output var  logic [W-1:0] value,
	output var  logic         wrapped
);
	// whole state of one counter
	typedef struct packed {
		logic [W-1:0] cnt;    // running count
		logic         flag;   // sticky wrap flag
	} tally_t;

	tally_t st_q;   // registered state
	tally_t st_d;   // next state
	logic   wrap;   // increment at all ones

	////////////////////////////////////////////////////////////////
	// next state: clear beats load beats increment
	always_comb begin
		st_d = st_q;
		wrap = inc && !clear && !load && (&st_q.cnt);
		if (clear) begin
			st_d.cnt = '0;
		end else if (load) begin
			st_d.cnt = load_val;
		end else if (inc) begin
			st_d.cnt = st_q.cnt + 1'b1;
		end
		// clear first so a wrap in the same cycle survives
		if (flag_clr) begin
			st_d.flag = 1'b0;
		end
		if (wrap) begin
			st_d.flag = 1'b1;
		end
	end

	// state register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign value   = st_q.cnt;
	assign wrapped = st_q.flag;

	////////////////////////////////////////////////////////////////
	a_count_step: assert property (@(posedge mclk) disable iff (!rst_n)
		inc && !clear && !load |=> value == $past(value) + 1'b1)
		else $error("counter did not step by one");
	a_wrap_flag: assert property (@(posedge mclk) disable iff (!rst_n)
		inc && !clear && !load && (&value) |=> wrapped && value == '0)
		else $error("wrap did not set flag");
endmodule // event_tally
`default_nettype wire

// file: rtl/perf_event_monitor.sv
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module perf_event_monitor
	import perf_monitor_pkg::*;
(
	input  wire logic                     mclk,
	input  wire logic                     rst_n,
	input  wire logic [11:0]              reg_addr,
	input  wire logic [31:0]              reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output var  logic [31:0]              reg_rdata,
	input  wire logic                     noninvasive_debug_allow,
	input  wire logic                     secure_noninvasive_allow,
	input  wire logic [SLV_W-1:0]         slave_evt,
	input  wire logic [SLV_W-1:0]         slave_evt_secure,
	input  wire logic [SLV_PORTS-1:0]     slave_read_valid,
	input  wire logic [SLV_PORTS-1:0]     slave_read_ready,
	input  wire logic [MST_W-1:0]         master_evt,
	input  wire logic [MST_W-1:0]         master_evt_secure,
	input  wire logic [2*MST_PORTS-1:0]   master_retry_sched,
	input  wire logic [SLV_PORTS*QOS_W-1:0] qos_rd_level,
	input  wire logic [SLV_PORTS*QOS_W-1:0] qos_wr_level,
	output var  logic [VEC_W-1:0]         event_vector,
	output var  logic [SLV_PORTS*QOS_W-1:0] qos_rd_out,
	output var  logic [SLV_PORTS*QOS_W-1:0] qos_wr_out,
	output var  logic [NUM_CNT-1:0]       counter_wrap_irq_n
);
	// registered state of the monitor, apart from the counters held in event_tally
	typedef struct packed {
		logic [VEC_W-1:0]             evt_vec;  // exported pulses
		logic [SLV_PORTS*QOS_W-1:0]   qos_rd;   // read regulator copy
		logic [SLV_PORTS*QOS_W-1:0]   qos_wr;   // write regulator copy
		logic [31:0]                  rdata;    // read answer
		logic                         glob_en;  // control bit 0
		logic                         cyc_en;   // cycle counter enable
		logic [NUM_CNT-1:0]           cnt_en;   // per counter enable
		logic [NUM_CNT*8-1:0]         esel;     // event select codes
		logic [NUM_CNT-1:0]           irq_n;    // wrap outputs
	} mon_state_t;

	mon_state_t              st_q;        // registered state
	mon_state_t              st_d;        // next state
	logic [VEC_W-1:0]        qual_vec;    // filtered events
	logic [CNT_W-1:0]        cnt_val [NUM_CNT]; // counter values
	logic [NUM_CNT-1:0]      cnt_flag;    // counter wrap flags
	logic [NUM_CNT-1:0]      cnt_inc;     // counter increments
	logic [NUM_CNT-1:0]      cnt_load;    // bus writes to counts
	logic [NUM_CNT-1:0]      cnt_fclr;    // bus clears of flags
	logic [CNT_W-1:0]        cyc_val;     // cycle counter value
	logic                    cyc_flag;    // cycle wrap flag
	logic                    cyc_inc;     // cycle increment
	logic                    wr_ctrl;     // write to control reg
	logic                    clr_evt;     // clear event counters
	logic                    clr_cyc;     // clear cycle counter
	logic                    in_page;     // address in counter page
	logic [3:0]              page_idx;    // counter number in page

	////////////////////////////////////////////////////////////////
	// event qualification per slave port
	for (genvar p = 0; p < SLV_PORTS; p++) begin : g_slv
		logic [SLV_EVTS-1:0] raw;  // events of this port
		logic [SLV_EVTS-1:0] sec;  // secure attribute
		always_comb begin
			raw = slave_evt[p*SLV_EVTS +: SLV_EVTS];
			sec = slave_evt_secure[p*SLV_EVTS +: SLV_EVTS];
			// valid high, ready low: one pulse per stalled cycle
			raw[EVT_RD_STALL] = slave_read_valid[p] &&
				!slave_read_ready[p];
		end
		// secure pulses pass only with secure allow
		assign qual_vec[p*SLV_EVTS +: SLV_EVTS] = raw &
			(~sec | {SLV_EVTS{secure_noninvasive_allow}}) &
			{SLV_EVTS{noninvasive_debug_allow}};
	end

	// event qualification per master port
	for (genvar m = 0; m < MST_PORTS; m++) begin : g_mst
		logic [MST_EVTS-1:0] raw;  // events of this port
		always_comb begin
			raw = master_evt[m*MST_EVTS +: MST_EVTS];
			// two retries at once still make one pulse
			raw[EVT_RETRY] = |master_retry_sched[2*m +: 2];
		end
		assign qual_vec[SLV_W + m*MST_EVTS +: MST_EVTS] = raw &
			(~master_evt_secure[m*MST_EVTS +: MST_EVTS] |
			 {MST_EVTS{secure_noninvasive_allow}} |
			 MST_NOSEC_MASK) &
			{MST_EVTS{noninvasive_debug_allow}};
	end

	////////////////////////////////////////////////////////////////
	// map a select code to a vector index; msb says valid
	function automatic logic [8:0] sel_index(input logic [7:0] code);
		logic [2:0] src;  // source port code
		logic [4:0] num;  // event number
		logic [7:0] idx;  // vector index
		logic       ok;   // number exists for source
		src = code[7:5];
		num = code[4:0];
		if (src < 3'(SLV_PORTS)) begin
			ok  = num < 5'(SLV_EVTS);
			idx = 8'({5'h00, src} * 8'(SLV_EVTS)) + {3'h0, num};
		end else begin
			ok  = num < 5'(MST_EVTS);
			idx = 8'(SLV_W) + 8'({5'h00, src - 3'(SLV_PORTS)} *
				8'(MST_EVTS)) + {3'h0, num};
		end
		return {ok, idx};
	endfunction

	////////////////////////////////////////////////////////////////
	// bus decode for counter side effects
	assign in_page  = reg_addr[11:8] == CNT_PAGE;
	assign page_idx = reg_addr[7:4];
	assign wr_ctrl  = reg_wr && reg_addr == OFF_CTRL;
	assign clr_evt  = wr_ctrl && reg_wdata[CTRL_RST_EVT_BIT];
	assign clr_cyc  = wr_ctrl && reg_wdata[CTRL_RST_CYC_BIT];
	assign cyc_inc  = st_q.glob_en && st_q.cyc_en;

	// counters; the selected bit is the registered vector bit
	for (genvar c = 0; c < NUM_CNT; c++) begin : g_cnt
		logic [8:0] sel;  // decoded selection
		logic       hit;  // this counter addressed
		assign sel = sel_index(st_q.esel[c*8 +: 8]);
		assign hit = reg_wr && in_page && page_idx == 4'(c);
		assign cnt_inc[c] = st_q.glob_en && st_q.cnt_en[c] &&
			sel[8] && st_q.evt_vec[sel[7:0]];
		assign cnt_load[c] = hit && reg_addr[3:0] == SUB_CNT;
		assign cnt_fclr[c] = hit && reg_addr[3:0] == SUB_FLAG &&
			reg_wdata[FLAG_BIT];
		event_tally #(.W(CNT_W)) u_tally (
			.mclk     (mclk),
			.rst_n    (rst_n),
			.inc      (cnt_inc[c]),
			.clear    (clr_evt),
			.load     (cnt_load[c]),
			.load_val (reg_wdata),
			.flag_clr (cnt_fclr[c]),
			.value    (cnt_val[c]),
			.wrapped  (cnt_flag[c])
		);
	end

	// free cycle counter
	event_tally #(.W(CNT_W)) u_cycle (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.inc      (cyc_inc),
		.clear    (clr_cyc),
		.load     (reg_wr && reg_addr == OFF_CYC_CNT),
		.load_val (reg_wdata),
		.flag_clr (reg_wr && reg_addr == OFF_CYC_FLAG &&
			reg_wdata[FLAG_BIT]),
		.value    (cyc_val),
		.wrapped  (cyc_flag)
	);

	////////////////////////////////////////////////////////////////
	// next state: pulses, mirrors, register writes and reads
	always_comb begin
		st_d = st_q;
		// fresh every cycle, so each pulse lasts one cycle
		st_d.evt_vec = qual_vec;
		st_d.qos_rd  = qos_rd_level;
		st_d.qos_wr  = qos_wr_level;
		st_d.irq_n   = ~cnt_flag;
		st_d.rdata   = '0;
		// register writes
		if (reg_wr) begin
			if (reg_addr == OFF_CTRL) begin
				st_d.glob_en = reg_wdata[CTRL_EN_BIT];
			end else if (reg_addr == OFF_CYC_CFG) begin
				st_d.cyc_en = reg_wdata[CFG_EN_BIT];
			end else if (in_page && page_idx < 4'(NUM_CNT)) begin
				if (reg_addr[3:0] == SUB_SEL) begin
					st_d.esel[page_idx[1:0]*8 +: 8] = reg_wdata[7:0];
				end else if (reg_addr[3:0] == SUB_CFG) begin
					st_d.cnt_en[page_idx[1:0]] =
						reg_wdata[CFG_EN_BIT];
				end
			end
		end
		// register reads; unmapped offsets answer zero
		if (reg_rd) begin
			if (reg_addr == OFF_CTRL) begin
				st_d.rdata = {31'h0, st_q.glob_en};
			end else if (reg_addr == OFF_CYC_CNT) begin
				st_d.rdata = cyc_val;
			end else if (reg_addr == OFF_CYC_CFG) begin
				st_d.rdata = {31'h0, st_q.cyc_en};
			end else if (reg_addr == OFF_CYC_FLAG) begin
				st_d.rdata = {31'h0, cyc_flag};
			end else if (in_page && page_idx < 4'(NUM_CNT)) begin
				case (reg_addr[3:0])
					SUB_SEL: begin
						st_d.rdata = {24'h0,
							st_q.esel[page_idx[1:0]*8 +: 8]};
					end
					SUB_CNT: begin
						st_d.rdata = cnt_val[page_idx[1:0]];
					end
					SUB_CFG: begin
						st_d.rdata = {31'h0, st_q.cnt_en[page_idx[1:0]]};
					end
					SUB_FLAG: begin
						st_d.rdata = {31'h0, cnt_flag[page_idx[1:0]]};
					end
					default: begin
						st_d.rdata = '0;
					end
				endcase
			end
		end
	end

	// state register; wrap outputs idle high
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q         <= '0;
			st_q.esel    <= {NUM_CNT{ESEL_RST}};
			st_q.glob_en <= EN_RST;
			st_q.irq_n   <= '1;
		end else begin
			st_q <= st_d;
		end
	end

	assign event_vector       = st_q.evt_vec;
	assign qos_rd_out         = st_q.qos_rd;
	assign qos_wr_out         = st_q.qos_wr;
	assign reg_rdata          = st_q.rdata;
	assign counter_wrap_irq_n = st_q.irq_n;

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// a write of both reset bits with the enable set
	sequence s_reset_write;
		reg_wr && reg_addr == OFF_CTRL && reg_wdata[2:0] == 3'h7;
	endsequence
	sequence s_counters_cleared;
		cyc_val == '0 && cnt_val[0] == '0 && st_q.glob_en;
	endsequence

	a_gate_debug: assert property (!noninvasive_debug_allow
		|=> event_vector == '0)
		else $error("events exported without debug allow");
	a_secure_block: assert property (slave_evt[0] &&
		slave_evt_secure[0] && !secure_noninvasive_allow
		|=> !event_vector[0])
		else $error("secure slave event leaked");
	a_nosec_master: assert property (master_evt[2] &&
		noninvasive_debug_allow |=> event_vector[SLV_W + 2])
		else $error("unattributed master event dropped");
	a_stall_bit: assert property (noninvasive_debug_allow &&
		slave_read_valid[1] && !slave_read_ready[1] &&
		!slave_evt_secure[SLV_EVTS + EVT_RD_STALL]
		|=> event_vector[SLV_EVTS + EVT_RD_STALL])
		else $error("read data stall not pulsed");
	a_retry_single: assert property (noninvasive_debug_allow &&
		master_retry_sched[1:0] == 2'h3 &&
		!master_evt_secure[EVT_RETRY] ##1 !(|master_retry_sched[1:0])
		|-> event_vector[SLV_W + EVT_RETRY] ##1
		!event_vector[SLV_W + EVT_RETRY])
		else $error("retry pulse not single");
	// sampled reset keeps the release edge itself out of the check
	a_qos_track: assert property (rst_n |=>
		qos_rd_out == $past(qos_rd_level) &&
		qos_wr_out == $past(qos_wr_level))
		else $error("qos outputs not following");
	a_irq_follow: assert property ($rose(cnt_flag[0])
		|=> !counter_wrap_irq_n[0])
		else $error("wrap output not asserted");
	a_reset_field: assert property (s_reset_write
		|=> s_counters_cleared)
		else $error("reset field did not clear counters");
	a_read_slot: assert property (reg_rd && reg_addr == OFF_CYC_CFG
		|=> reg_rdata == {31'h0, $past(st_q.cyc_en)})
		else $error("read answer not in next cycle");

	////////////////////////////////////////////////////////////////
	// gates: without a register write there is no load and no clear
	// counting stops while the global enable is low
	a_global_gate: assert property (!st_q.glob_en && !reg_wr
		|=> cnt_val[1] == $past(cnt_val[1]))
		else $error("counter moved while globally disabled");
	// a disabled counter holds its value
	a_counter_off: assert property (!st_q.cnt_en[3] && !reg_wr
		|=> cnt_val[3] == $past(cnt_val[3]))
		else $error("disabled counter moved");
	// both enables set: one clock, one step
	a_cycle_step: assert property (cyc_inc && !reg_wr
		|=> cyc_val == $past(cyc_val) + 1'b1)
		else $error("cycle counter missed a clock");
	// output released once the flag is gone
	a_irq_release: assert property (!cnt_flag[1]
		|=> counter_wrap_irq_n[1])
		else $error("wrap output low without flag");
	// secure allow lets secure pulses through
	a_secure_pass: assert property (noninvasive_debug_allow &&
		secure_noninvasive_allow && slave_evt[4*SLV_EVTS]
		|=> event_vector[4*SLV_EVTS])
		else $error("allowed secure event dropped");
	// read handshake event lands at its own number
	a_slave_group: assert property (noninvasive_debug_allow &&
		slave_evt[2*SLV_EVTS+3] && !slave_evt_secure[2*SLV_EVTS+3]
		|=> event_vector[2*SLV_EVTS+3])
		else $error("slave read event misplaced");
	// write handshake event lands at its own number
	a_write_any: assert property (noninvasive_debug_allow &&
		slave_evt[SLV_EVTS+12] && !slave_evt_secure[SLV_EVTS+12]
		|=> event_vector[SLV_EVTS+12])
		else $error("slave write event misplaced");
	// write tracker stall passes each stalled cycle
	a_write_stall: assert property (noninvasive_debug_allow &&
		slave_evt[19] && !slave_evt_secure[19]
		|=> event_vector[19])
		else $error("write stall event dropped");
	// master groups sit above all slave groups
	a_master_group: assert property (noninvasive_debug_allow &&
		master_evt[2*MST_EVTS+5] && !master_evt_secure[2*MST_EVTS+5]
		|=> event_vector[SLV_W+2*MST_EVTS+5])
		else $error("master event misplaced");
	// no input pulse, no exported pulse: bits never linger
	a_pulse_drop: assert property (!slave_evt[SLV_EVTS]
		|=> !event_vector[SLV_EVTS])
		else $error("event bit held beyond its pulse");
endmodule // perf_event_monitor
`default_nettype wire

// file: rtl/perf_monitor_pkg.sv
package perf_monitor_pkg;
	// port and event geometry of the exported vector
	localparam int SLV_PORTS = 5;
	localparam int SLV_EVTS  = 21;
	localparam int MST_PORTS = 3;
	localparam int MST_EVTS  = 18;
	localparam int SLV_W     = SLV_PORTS * SLV_EVTS;
	localparam int MST_W     = MST_PORTS * MST_EVTS;
	localparam int VEC_W     = SLV_W + MST_W;
	localparam int QOS_W     = 4;
	localparam int NUM_CNT   = 4;
	localparam int CNT_W     = 32;
	// event numbers with special sources
	localparam int EVT_RD_STALL = 11;
	localparam int EVT_RETRY    = 17;
	// master events without a security attribute: 0x2 and 0x09..0x10
	localparam logic [MST_EVTS-1:0] MST_NOSEC_MASK = 18'h1FE04;
	// register offsets
	localparam logic [11:0] OFF_CTRL     = 12'h000;
	localparam logic [11:0] OFF_CYC_CNT  = 12'h004;
	localparam logic [11:0] OFF_CYC_CFG  = 12'h008;
	localparam logic [11:0] OFF_CYC_FLAG = 12'h00C;
	localparam logic [3:0]  CNT_PAGE     = 4'h1;
	localparam logic [3:0]  SUB_SEL      = 4'h0;
	localparam logic [3:0]  SUB_CNT      = 4'h4;
	localparam logic [3:0]  SUB_CFG      = 4'h8;
	localparam logic [3:0]  SUB_FLAG     = 4'hC;
	// field positions
	localparam int CTRL_EN_BIT      = 0;
	localparam int CTRL_RST_EVT_BIT = 1;
	localparam int CTRL_RST_CYC_BIT = 2;
	localparam int CFG_EN_BIT       = 0;
	localparam int FLAG_BIT         = 0;
	// reset values
	localparam logic [7:0]  ESEL_RST = 8'h00;
	localparam logic        EN_RST   = 1'b0;
endpackage

// file: test/event_source.sv
`timescale 1ns/1ns
`default_nettype none
module event_source
	import perf_monitor_pkg::*;
(
	input  wire logic                       mclk,
	input  wire logic                       active,
	output var  logic [SLV_W-1:0]           slave_evt,
	output var  logic [SLV_W-1:0]           slave_evt_secure,
	output var  logic [SLV_PORTS-1:0]       slave_read_valid,
	output var  logic [SLV_PORTS-1:0]       slave_read_ready,
	output var  logic [MST_W-1:0]           master_evt,
	output var  logic [MST_W-1:0]           master_evt_secure,
	output var  logic [2*MST_PORTS-1:0]     master_retry_sched,
	output var  logic [SLV_PORTS*QOS_W-1:0] qos_rd_level,
	output var  logic [SLV_PORTS*QOS_W-1:0] qos_wr_level
);
	////////////////////////////////////////////////////////////////////
	// quiet start so no port logic output is unknown at time zero
	initial begin
		slave_evt = '0;
		slave_evt_secure = '0;
		slave_read_valid = '0;
		slave_read_ready = '0;
		master_evt = '0;
		master_evt_secure = '0;
		master_retry_sched = '0;
		qos_rd_level = '0;
		qos_wr_level = '0;
	end
	////////////////////////////////////////////////////////////////////
	// random pulses while active, each bit high in about one cycle of four, dense enough to collide often
	always @(posedge mclk) begin
		for (int i = 0; i < SLV_W; i++) begin
			slave_evt[i]        <= active && ($urandom % 4 == 0);
			slave_evt_secure[i] <= 1'($urandom);
		end
		for (int i = 0; i < MST_W; i++) begin
			master_evt[i]        <= active && ($urandom % 4 == 0);
			master_evt_secure[i] <= 1'($urandom);
		end
		// stall cycles show as raw valid high, ready low levels
		slave_read_valid <= active ? SLV_PORTS'($urandom) : '0;
		slave_read_ready <= SLV_PORTS'($urandom);
		// both retry strobes of a port may fire in the same cycle
		master_retry_sched <= active ? 6'($urandom) : '0;
		qos_rd_level <= 20'($urandom);
		qos_wr_level <= 20'($urandom);
	end
endmodule // event_source
`default_nettype wire

// file: test/perf_event_monitor_tb.sv
`timescale 1ns/1ns
`default_nettype none
module perf_event_monitor_tb import perf_monitor_pkg::*;;
	logic              mclk = 0, rst_n = 0;
	logic [11:0]       reg_addr = '0;
	logic [31:0]       reg_wdata = '0, reg_rdata, d, c0;
	logic              reg_wr = 0, reg_rd = 0, allow = 0, sallow = 0;
	logic              active = 0, gen = 0; // traffic on, global enable
	logic              was_up = 0; // one edge already out of reset
	logic [SLV_W-1:0]  s_evt, s_sec;
	logic [4:0]        s_val, s_rdy;
	logic [MST_W-1:0]  m_evt, m_sec;
	logic [5:0]        m_rty;
	logic [19:0]       q_rd, q_wr, qo_rd, qo_wr;
	logic [VEC_W-1:0]  event_vector, ev_exp = '0; // seen, expected
	logic [39:0]       q_exp = '0;
	logic [3:0]        irq_n, mflag = '0, en = '0;
	logic [31:0]       mcnt [4];  // counter reference values
	logic [7:0]        sel [4];
	int                miscompares = 0, cmp_count = 0;
	always #10 mclk = ~mclk;
	////////////////////////////////////////////////////////////////////
	event_source event_source_i (.mclk(mclk), .active(active),
		.slave_evt(s_evt), .slave_evt_secure(s_sec),
		.slave_read_valid(s_val), .slave_read_ready(s_rdy),
		.master_evt(m_evt), .master_evt_secure(m_sec),
		.master_retry_sched(m_rty), .qos_rd_level(q_rd),
		.qos_wr_level(q_wr));
	perf_event_monitor perf_event_monitor_i (.mclk(mclk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.noninvasive_debug_allow(allow),
		.secure_noninvasive_allow(sallow), .slave_evt(s_evt),
		.slave_evt_secure(s_sec), .slave_read_valid(s_val),
		.slave_read_ready(s_rdy), .master_evt(m_evt),
		.master_evt_secure(m_sec), .master_retry_sched(m_rty),
		.qos_rd_level(q_rd), .qos_wr_level(q_wr),
		.event_vector(event_vector), .qos_rd_out(qo_rd),
		.qos_wr_out(qo_wr), .counter_wrap_irq_n(irq_n));
	////////////////////////////////////////////////////////////////////
	// reference filter: bit index of a select code, -1 for none
	function automatic int sel_bit(logic [7:0] c);
		if (c[7:5] < 5)
			return c[4:0] < SLV_EVTS ? c[7:5] * SLV_EVTS + c[4:0] : -1;
		return c[4:0] < MST_EVTS ?
			SLV_W + (c[7:5] - 5) * MST_EVTS + c[4:0] : -1;
	endfunction
	// what the vector must show one cycle after the current inputs
	function automatic logic [VEC_W-1:0] expv();
		logic [VEC_W-1:0] v;
		logic             e, s;
		int               i;
		v = '0;
		for (int p = 0; p < SLV_PORTS; p++) begin
			for (int b = 0; b < SLV_EVTS; b++) begin
				i = p * SLV_EVTS + b;
				e = (b == EVT_RD_STALL) ? s_val[p] & ~s_rdy[p] : s_evt[i];
				s = s_sec[i];
				v[i] = allow & e & (~s | sallow);
			end
		end
		for (int m = 0; m < MST_PORTS; m++) begin
			for (int b = 0; b < MST_EVTS; b++) begin
				i = m * MST_EVTS + b;
				e = (b == EVT_RETRY) ? |m_rty[2*m+:2] : m_evt[i];
				s = m_sec[i] & ~MST_NOSEC_MASK[b];
				v[SLV_W+i] = allow & e & (~s | sallow);
			end
		end
		return v;
	endfunction
	////////////////////////////////////////////////////////////////////
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chkv(string n, logic [VEC_W-1:0] e, logic [VEC_W-1:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d miscompares %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// one-cycle strobes, changed just after an edge
	task automatic wr(logic [11:0] a, logic [31:0] v);
		@(posedge mclk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge mclk);
		reg_wr <= 0;
	endtask
	task automatic rd(logic [11:0] a, output logic [31:0] v);
		@(posedge mclk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 0;
		@(negedge mclk);
		v = reg_rdata;
	endtask
	////////////////////////////////////////////////////////////////////
	// per-cycle compare and counter reference, away from the edge
	// the release edge still holds reset values, so skip its cycle
	always @(negedge mclk) begin
		if (rst_n && was_up) begin
			chkv("event_vector", ev_exp, event_vector);
			chkv("qos_out", VEC_W'(q_exp), VEC_W'({qo_wr, qo_rd}));
			for (int n = 0; n < NUM_CNT; n++) begin
				if (gen && en[n] && sel_bit(sel[n]) >= 0 &&
					ev_exp[sel_bit(sel[n])]) begin
					mcnt[n] = mcnt[n] + 1;
					if (mcnt[n] == 0) mflag[n] = 1;
				end
			end
		end
		ev_exp = expv();
		q_exp = {q_wr, q_rd};
		was_up = rst_n;
	end
	// hang guard
	initial begin
		repeat (100000) @(posedge mclk);
		miscompares++;
		give_verdict();
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		d = $urandom(88143);
		for (int n = 0; n < NUM_CNT; n++) sel[n] = 8'h00;
		repeat (6) @(posedge mclk);
		rst_n <= 1;
		chk("irq_n", 32'h0000000F, {28'h0, irq_n});
		for (int n = 0; n < NUM_CNT; n++) begin
			rd(12'(256 + 16 * n), d);
			chk("select_rst", 32'h00000000, d);
			rd(12'(264 + 16 * n), d);
			chk("enable_rst", 32'h00000000, d);
		end
		rd(12'h200, d);
		chk("unmapped", 32'h00000000, d);
		wr(12'h000, 32'h00000001);
		gen = 1;
		for (int r = 0; r < 4; r++) begin
			for (int n = 0; n < NUM_CNT; n++) begin
				sel[n] = {3'(r * 2 + n / 2), 5'($urandom_range(0, 22))};
				en[n] = !(r == 1 && n == 3);
				mcnt[n] = 32'hFFFFFFFF - $urandom_range(0, 3);
				mflag[n] = 0;
				wr(12'(256 + 16 * n), {24'h0, sel[n]});
				wr(12'(260 + 16 * n), mcnt[n]);
				wr(12'(264 + 16 * n), {31'h0, en[n]});
				wr(12'(268 + 16 * n), 32'h00000001);
			end
			allow <= (r != 2);
			sallow <= r[0];
			active <= 1;
			repeat (150) @(posedge mclk);
			active <= 0;
			repeat (4) @(posedge mclk);
			for (int n = 0; n < NUM_CNT; n++) begin
				rd(12'(260 + 16 * n), d);
				chk("count", mcnt[n], d);
				rd(12'(268 + 16 * n), d);
				chk("wrap_flag", {31'h0, mflag[n]}, d);
			end
			chk("irq_n", {28'h0, ~mflag}, {28'h0, irq_n});
		end
		wr(12'h008, 32'h00000001);
		rd(12'h004, c0);
		repeat (7) @(posedge mclk);
		rd(12'h004, d);
		chk("cycle_delta", 32'h00000009, d - c0);
		wr(12'h004, 32'hFFFFFFFC);
		repeat (8) @(posedge mclk);
		rd(12'h00C, d);
		chk("cycle_flag", 32'h00000001, d);
		wr(12'h00C, 32'h00000001);
		rd(12'h00C, d);
		chk("cycle_flag_clr", 32'h00000000, d);
		wr(12'h000, 32'h00000007);
		for (int n = 0; n < NUM_CNT; n++) mcnt[n] = 0;
		// zero at the write edge, one step before the read is taken
		rd(12'h004, d);
		chk("cycle_clr", 32'h00000001, d);
		rd(12'h000, d);
		chk("control", 32'h00000001, d);
		for (int n = 0; n < NUM_CNT; n++) begin
			rd(12'(260 + 16 * n), d);
			chk("count_clr", mcnt[n], d);
		end
		rd(12'h008, d);
		chk("cycle_en", 32'h00000001, d);
		give_verdict();
	end
endmodule // perf_event_monitor_tb
`default_nettype wire
